/* verilog/charger_status_pkg.sv */
package charger_status_pkg;

  // byte addresses of the 16-bit register: low byte holds faults, high byte holds state
  localparam logic [7:0] ADDR_STATE_FAULTS_LO = 8'h20;
  localparam logic [7:0] ADDR_STATE_FAULTS_HI = 8'h21;
  localparam logic [15:0] STATE_FAULTS_RESET = 16'h0000;

  // upper byte (offset 0x21) bit positions
  localparam int BIT_INPUT_PRESENT = 7;
  localparam int BIT_OPTIMIZER_FINISHED = 6;
  localparam int BIT_PEAK_ASSIST_ACTIVE = 5;
  localparam int BIT_INPUT_VOLTAGE_REGULATING = 4;
  localparam int BIT_INPUT_CURRENT_LIMITING = 3;
  localparam int BIT_FAST_CHARGING = 2;
  localparam int BIT_PRECHARGING = 1;
  localparam int BIT_REVERSE_OUTPUT_ACTIVE = 0;

  // lower byte (offset 0x20) bit positions
  localparam int BIT_INPUT_OVERVOLTAGE_FAULT = 7;
  localparam int BIT_BATTERY_OVERCURRENT_FAULT = 6;
  localparam int BIT_INPUT_OVERCURRENT_FAULT = 5;
  localparam int BIT_SYSTEM_OVERVOLTAGE = 4;
  localparam int BIT_SYSTEM_UNDERVOLTAGE = 3;
  localparam int BIT_FORCE_OFF_FAULT = 2;
  localparam int BIT_OUTPUT_OVERVOLTAGE_FAULT = 1;
  localparam int BIT_OUTPUT_UNDERVOLTAGE_FAULT = 0;

  // read-only latched fault bits of the lower byte, cleared by a host read
  localparam logic [7:0] FAULT_READ_CLEAR_MASK = 8'hE7;
  // host-writable fault bits of the lower byte
  localparam logic [7:0] FAULT_WRITE_MASK = 8'h18;

  // synchroniser input vector positions
  localparam int SYN_VBUS_IN_WINDOW = 0;
  localparam int SYN_OPTIMIZER_DONE = 1;
  localparam int SYN_VOLT_REG = 2;
  localparam int SYN_CURR_REG = 3;
  localparam int SYN_FAST = 4;
  localparam int SYN_PRE = 5;
  localparam int SYN_REVERSE = 6;
  localparam int SYN_OUT_VOLT_REG = 7;
  localparam int SYN_THERMAL = 8;
  localparam int SYN_BAT_OV = 9;
  localparam int SYN_ASSIST_PIN = 10;
  localparam int SYN_CONVERTER_READY = 11;
  localparam int SYN_FAULT_BASE = 12;
  localparam int SYN_WIDTH = 20;

  localparam int SYNC_STAGES = 2;

endpackage : charger_status_pkg

/* verilog/charger_status_register.sv */
`timescale 1ns/1ps
// Summary of operation
// R1 - input present while bus voltage within window
// R2 - charger good always implies input present
// R3 - listed shutdown conditions drop charger good
// R4 - optimizer finished set once routine completes
// R5 - assist mode entered only by host command
// R6 - exit on command or fault, sets exit flag
// R7 - host: pin high, disable bit zero enables
// R8 - assist entry disables regulation, swaps alert sources
// R9 - assist exit re-enables regulation; alert sources keep entry setting
// R10 - voltage regulating flag: forward or reverse regulation
// R11 - current limiting flag during forward regulation
// R12 - fast charging flag follows fast charge
// R13 - precharging flag follows pre-charge
// R14 - reverse output flag follows reverse output
// R15 - resets zero; only two fault bits writable
// R16 - read-only faults latch until host read
// R17 - overvoltage latch keeps converter off until cleared
// R18 - writes to read-only bits change nothing
module charger_status_register #(
  parameter int SYNC_STAGES = charger_status_pkg::SYNC_STAGES
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // analog status pins (asynchronous)
  input wire logic vbusInWindow,
  input wire logic optimizerDone,
  input wire logic inputVoltageRegulation,
  input wire logic outputVoltageRegulation,
  input wire logic inputCurrentRegulation,
  input wire logic fastChargeState,
  input wire logic prechargeState,
  input wire logic reverseOutputState,
  input wire logic converterReady,
  input wire logic thermalShutdown,
  input wire logic batteryOvervoltage,
  input wire logic [7:0] faultEvents,
  input wire logic reverseAssistPin,
  // configuration from neighbouring registers (same clock)
  input wire logic assistDisable,
  input wire logic alertCfgLoad,
  input wire logic adapterOkCfg,
  input wire logic systemVoltageCfg,
  input wire logic assistExitClear,
  // byte register port of the i2c target
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // status and control outputs
  output logic chargerGood,
  output logic inputPresent,
  output logic peakAssistActive,
  output logic assistExitFlag,
  output logic processorHotPullLow,
  output logic regulationEnable,
  output logic adapterOkAlertSourceEn,
  output logic systemVoltageAlertSourceEn,
  output logic converterEnable
);

  if (SYNC_STAGES < 2) begin : g_bad_stages
    $error("SYNC_STAGES must be at least 2");
  end

  logic [charger_status_pkg::SYN_WIDTH-1:0] rawIn;
  logic [charger_status_pkg::SYN_WIDTH-1:0] syncIn;
  logic [7:0] stateByte;
  logic [7:0] faultByte;
  logic [7:0] faultNow;
  logic assistCmd;
  logic assistFault;
  logic next_peakAssistActive;
  logic readLo;
  logic writeLo;

  assign rawIn = {faultEvents, converterReady, reverseAssistPin, batteryOvervoltage,
    thermalShutdown, outputVoltageRegulation, reverseOutputState, prechargeState,
    fastChargeState, inputCurrentRegulation, inputVoltageRegulation, optimizerDone,
    vbusInWindow};

  // two-flop synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < charger_status_pkg::SYN_WIDTH; gi++) begin : g_sync
      logic [SYNC_STAGES-1:0] stages;
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          stages <= '0;
        end else if (ce) begin
          stages <= {stages[SYNC_STAGES-2:0], rawIn[gi]};
        end
      end
      assign syncIn[gi] = stages[SYNC_STAGES-1];
    end
  endgenerate

  assign faultNow = syncIn[charger_status_pkg::SYN_FAULT_BASE +: 8];
  assign readLo = regRead && (regAddr == charger_status_pkg::ADDR_STATE_FAULTS_LO);
  assign writeLo = regWrite && (regAddr == charger_status_pkg::ADDR_STATE_FAULTS_LO);
  assign assistCmd = syncIn[charger_status_pkg::SYN_ASSIST_PIN] && !assistDisable; // R7
  assign assistFault = (|faultNow) || syncIn[charger_status_pkg::SYN_THERMAL]
    || syncIn[charger_status_pkg::SYN_BAT_OV];

  // upper byte: live state, read-only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stateByte <= charger_status_pkg::STATE_FAULTS_RESET[15:8]; // R15
    end else if (ce) begin
      stateByte[charger_status_pkg::BIT_INPUT_PRESENT] <=
        syncIn[charger_status_pkg::SYN_VBUS_IN_WINDOW]; // R1
      stateByte[charger_status_pkg::BIT_OPTIMIZER_FINISHED] <=
        syncIn[charger_status_pkg::SYN_OPTIMIZER_DONE]; // R4
      stateByte[charger_status_pkg::BIT_PEAK_ASSIST_ACTIVE] <= next_peakAssistActive; // R5
      stateByte[charger_status_pkg::BIT_INPUT_VOLTAGE_REGULATING] <=
        (syncIn[charger_status_pkg::SYN_VOLT_REG] && !syncIn[charger_status_pkg::SYN_REVERSE])
        || (syncIn[charger_status_pkg::SYN_OUT_VOLT_REG]
        && syncIn[charger_status_pkg::SYN_REVERSE]); // R10
      stateByte[charger_status_pkg::BIT_INPUT_CURRENT_LIMITING] <=
        syncIn[charger_status_pkg::SYN_CURR_REG]
        && !syncIn[charger_status_pkg::SYN_REVERSE]; // R11
      stateByte[charger_status_pkg::BIT_FAST_CHARGING] <=
        syncIn[charger_status_pkg::SYN_FAST]; // R12
      stateByte[charger_status_pkg::BIT_PRECHARGING] <=
        syncIn[charger_status_pkg::SYN_PRE]; // R13
      stateByte[charger_status_pkg::BIT_REVERSE_OUTPUT_ACTIVE] <=
        syncIn[charger_status_pkg::SYN_REVERSE]; // R14
    end
  end

  assign inputPresent = stateByte[charger_status_pkg::BIT_INPUT_PRESENT];
  assign peakAssistActive = stateByte[charger_status_pkg::BIT_PEAK_ASSIST_ACTIVE];

  // peak assist entry and exit
  always_comb begin
    next_peakAssistActive = peakAssistActive;
    if (peakAssistActive) begin
      if (!assistCmd || assistFault) begin
        next_peakAssistActive = 1'b0; // R6
      end
    end else if (assistCmd && !assistFault) begin
      next_peakAssistActive = 1'b1; // R5
    end
  end

  // exit flag: set on assist exit, cleared by host; set wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      assistExitFlag <= 1'b0;
    end else if (ce) begin
      if (peakAssistActive && !next_peakAssistActive) begin
        assistExitFlag <= 1'b1; // R6
      end else if (assistExitClear) begin
        assistExitFlag <= 1'b0;
      end
    end
  end

  assign processorHotPullLow = assistExitFlag; // R6
  assign regulationEnable = !peakAssistActive; // R8 R9

  // alert source selection
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      adapterOkAlertSourceEn <= 1'b0;
      systemVoltageAlertSourceEn <= 1'b0;
    end else if (ce) begin
      if (!peakAssistActive && next_peakAssistActive) begin
        adapterOkAlertSourceEn <= 1'b0; // R8
        systemVoltageAlertSourceEn <= 1'b1; // R8
      end else if (alertCfgLoad) begin
        adapterOkAlertSourceEn <= adapterOkCfg;
        systemVoltageAlertSourceEn <= systemVoltageCfg;
      end
    end
  end

  // lower byte: latched faults; set wins over read or write clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      faultByte <= charger_status_pkg::STATE_FAULTS_RESET[7:0]; // R15
    end else if (ce) begin
      for (int b = 0; b < 8; b++) begin
        if (faultNow[b]) begin
          faultByte[b] <= 1'b1; // R16 R17
        end else if (charger_status_pkg::FAULT_WRITE_MASK[b]) begin
          if (writeLo) begin
            faultByte[b] <= regWrData[b]; // R15 R17
          end
        end else if (readLo) begin
          faultByte[b] <= 1'b0; // R16 R18
        end
      end
    end
  end

  // converter held off while overvoltage latch stands
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      converterEnable <= 1'b0;
    end else if (ce) begin
      converterEnable <= !faultByte[charger_status_pkg::BIT_SYSTEM_OVERVOLTAGE]
        && !faultNow[charger_status_pkg::BIT_SYSTEM_OVERVOLTAGE]; // R17
    end
  end

  // charger good
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chargerGood <= 1'b0;
    end else if (ce) begin
      chargerGood <= syncIn[charger_status_pkg::SYN_CONVERTER_READY]
        && syncIn[charger_status_pkg::SYN_VBUS_IN_WINDOW]
        && stateByte[charger_status_pkg::BIT_INPUT_PRESENT] // R2
        && !faultNow[charger_status_pkg::BIT_FORCE_OFF_FAULT]
        && !faultNow[charger_status_pkg::BIT_INPUT_OVERCURRENT_FAULT]
        && !syncIn[charger_status_pkg::SYN_THERMAL]
        && !faultByte[charger_status_pkg::BIT_SYSTEM_OVERVOLTAGE]
        && !faultByte[charger_status_pkg::BIT_SYSTEM_UNDERVOLTAGE]
        && !syncIn[charger_status_pkg::SYN_BAT_OV]; // R3
    end
  end

  // read data: registered one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else if (ce) begin
      regRdValid <= regRead;
      if (regRead) begin
        if (regAddr == charger_status_pkg::ADDR_STATE_FAULTS_LO) begin
          regRdData <= faultByte;
        end else if (regAddr == charger_status_pkg::ADDR_STATE_FAULTS_HI) begin
          regRdData <= stateByte;
        end else begin
          regRdData <= 8'h00;
        end
      end
    end
  end

  // checks
  property p_present_follows_window;
    @(posedge ref_clk) disable iff (srst)
      ce && $past(ce) |-> inputPresent == $past(syncIn[charger_status_pkg::SYN_VBUS_IN_WINDOW]);
  endproperty
  a_present_follows_window: assert property (p_present_follows_window) // R1
    else $error("input present does not follow window");

  property p_good_implies_present;
    @(posedge ref_clk) disable iff (srst) chargerGood |-> inputPresent;
  endproperty
  a_good_implies_present: assert property (p_good_implies_present) // R2
    else $error("charger good without input present");

  property p_shutdown_drops_good;
    @(posedge ref_clk) disable iff (srst)
      ce && syncIn[charger_status_pkg::SYN_THERMAL] |=> !chargerGood;
  endproperty
  a_shutdown_drops_good: assert property (p_shutdown_drops_good) // R3
    else $error("charger good during thermal shutdown");

  property p_entry_needs_cmd;
    @(posedge ref_clk) disable iff (srst)
      $rose(peakAssistActive) |-> $past(assistCmd);
  endproperty
  a_entry_needs_cmd: assert property (p_entry_needs_cmd) // R5
    else $error("assist entered without host command");

  property p_exit_sets_flag;
    @(posedge ref_clk) disable iff (srst)
      ce && $fell(peakAssistActive) |-> ##[0:1] assistExitFlag && processorHotPullLow;
  endproperty
  a_exit_sets_flag: assert property (p_exit_sets_flag) // R6
    else $error("assist exit did not raise exit flag");

  property p_fault_exits_assist;
    @(posedge ref_clk) disable iff (srst)
      ce && peakAssistActive && assistFault |=> !peakAssistActive || !$past(ce);
  endproperty
  a_fault_exits_assist: assert property (p_fault_exits_assist) // R6
    else $error("fault did not end assist");

  property p_entry_swaps_alerts;
    @(posedge ref_clk) disable iff (srst)
      $rose(peakAssistActive) |-> !adapterOkAlertSourceEn && systemVoltageAlertSourceEn
        && !regulationEnable;
  endproperty
  a_entry_swaps_alerts: assert property (p_entry_swaps_alerts) // R8
    else $error("assist entry did not reconfigure alerts");

  property p_exit_restores_reg;
    @(posedge ref_clk) disable iff (srst)
      $fell(peakAssistActive) && !$past(srst) && !$past(alertCfgLoad) |-> regulationEnable
        && $stable(adapterOkAlertSourceEn) && $stable(systemVoltageAlertSourceEn);
  endproperty
  a_exit_restores_reg: assert property (p_exit_restores_reg) // R9
    else $error("regulation not restored after assist");

  property p_read_clears_faults;
    @(posedge ref_clk) disable iff (srst)
      ce && readLo && !(|(faultNow & charger_status_pkg::FAULT_READ_CLEAR_MASK))
      |=> (faultByte & charger_status_pkg::FAULT_READ_CLEAR_MASK) == 8'h00;
  endproperty
  a_read_clears_faults: assert property (p_read_clears_faults) // R16
    else $error("read did not clear latched faults");

  property p_ovp_holds_converter;
    @(posedge ref_clk) disable iff (srst)
      faultByte[charger_status_pkg::BIT_SYSTEM_OVERVOLTAGE] && ce |=> !converterEnable;
  endproperty
  a_ovp_holds_converter: assert property (p_ovp_holds_converter) // R17
    else $error("converter enabled during overvoltage latch");

  property p_reset_zero;
    @(posedge ref_clk) srst |=> stateByte == 8'h00 && faultByte == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // R15
    else $error("register not zero after reset");

endmodule : charger_status_register

/* tb/host_controller_model.sv */
`timescale 1ns/1ps
module host_controller_model (
  // clock
  input wire logic ref_clk,
  // byte register port
  output logic regRead,
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  // assist control
  output logic reverseAssistPin,
  output logic assistDisable,
  output logic assistExitClear
);
  initial begin
    regRead = 1'b0;
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    reverseAssistPin = 1'b0;
    assistDisable = 1'b0;
    assistExitClear = 1'b0;
  end

  // read data only counts when valid comes back
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge ref_clk);
    regAddr = addr;
    regRead = 1'b1;
    @(negedge ref_clk);
    data = (regRdValid === 1'b1) ? regRdData : 8'hXX;
    regRead = 1'b0;
    regAddr = ~addr;
  endtask : rd

  // zero in bit 4 clears the overvoltage latch
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    regAddr = addr;
    regWrData = data;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
    regAddr = ~addr;
    regWrData = ~data;
  endtask : wr

  task automatic setAssist(input logic pin, input logic dis);
    @(negedge ref_clk);
    reverseAssistPin = pin;
    assistDisable = dis;
  endtask : setAssist

  task automatic clearExit();
    @(negedge ref_clk);
    assistExitClear = 1'b1;
    @(negedge ref_clk);
    assistExitClear = 1'b0;
  endtask : clearExit
endmodule : host_controller_model

/* tb/tb_charger_status_register.sv */
`timescale 1ns/1ps
module tb_charger_status_register;
  logic ref_clk, srst, ce, outputVoltageRegulation, converterReady, thermalShutdown;
  logic batteryOvervoltage, alertCfgLoad, adapterOkCfg, systemVoltageCfg;
  logic [6:0] pinVec;
  logic [7:0] faultEvents, d;
  logic regRead, regWrite, regRdValid, reverseAssistPin, assistDisable, assistExitClear;
  logic [7:0] regAddr, regWrData, regRdData;
  logic chargerGood, inputPresent, peakAssistActive, assistExitFlag, processorHotPullLow;
  logic regulationEnable, adapterOkAlertSourceEn, systemVoltageAlertSourceEn, converterEnable;
  logic [7:0] outs;
  int fails, nTests, cycles;

  assign outs = {chargerGood, inputPresent, peakAssistActive, assistExitFlag,
    processorHotPullLow, regulationEnable, adapterOkAlertSourceEn, systemVoltageAlertSourceEn};

  charger_status_register u_dut (.ref_clk(ref_clk), .srst(srst), .ce(ce),
    .vbusInWindow(pinVec[6]), .optimizerDone(pinVec[5]), .inputVoltageRegulation(pinVec[4]),
    .outputVoltageRegulation(outputVoltageRegulation), .inputCurrentRegulation(pinVec[3]),
    .fastChargeState(pinVec[2]), .prechargeState(pinVec[1]), .reverseOutputState(pinVec[0]),
    .converterReady(converterReady), .thermalShutdown(thermalShutdown),
    .batteryOvervoltage(batteryOvervoltage), .faultEvents(faultEvents),
    .reverseAssistPin(reverseAssistPin), .assistDisable(assistDisable),
    .alertCfgLoad(alertCfgLoad), .adapterOkCfg(adapterOkCfg),
    .systemVoltageCfg(systemVoltageCfg), .assistExitClear(assistExitClear),
    .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .chargerGood(chargerGood),
    .inputPresent(inputPresent), .peakAssistActive(peakAssistActive),
    .assistExitFlag(assistExitFlag), .processorHotPullLow(processorHotPullLow),
    .regulationEnable(regulationEnable), .adapterOkAlertSourceEn(adapterOkAlertSourceEn),
    .systemVoltageAlertSourceEn(systemVoltageAlertSourceEn), .converterEnable(converterEnable));

  host_controller_model u_host (.ref_clk(ref_clk), .regRead(regRead), .regWrite(regWrite),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .reverseAssistPin(reverseAssistPin), .assistDisable(assistDisable),
    .assistExitClear(assistExitClear));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests = nTests + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : w

  task automatic t_reset();
    chk(outs, 8'h04);
    chk({7'h00, converterEnable}, 8'h01);
    u_host.rd(8'h20, d);
    chk(d, 8'h00);
    u_host.rd(8'h21, d);
    chk(d, 8'h00);
  endtask : t_reset

  // one status pin at a time, then reverse-mode voltage regulation
  task automatic t_status();
    for (int k = 0; k < 9; k++) begin
      @(negedge ref_clk);
      pinVec = (k < 7) ? 7'(1 << k) : 7'h01;
      outputVoltageRegulation = (k == 8);
      if (k == 7) pinVec[4] = 1'b1;
      w(4);
      u_host.rd(8'h21, d);
      chk(d, (k < 5) ? 8'(1 << k) : (k < 7) ? 8'(1 << (k + 1)) : (k == 7) ? 8'h01 : 8'h11);
    end
    @(negedge ref_clk);
    pinVec = 7'h00;
    outputVoltageRegulation = 1'b0;
  endtask : t_status

  task automatic t_good();
    @(negedge ref_clk);
    pinVec = 7'h40;
    converterReady = 1'b1;
    w(5);
    chk(outs, 8'hC4);
    for (int k = 0; k < 4; k++) begin
      @(negedge ref_clk);
      thermalShutdown = (k == 0);
      batteryOvervoltage = (k == 1);
      faultEvents = (k == 2) ? 8'h20 : (k == 3) ? 8'h04 : 8'h00;
      w(4);
      chk(outs, 8'h44);
      @(negedge ref_clk);
      thermalShutdown = 1'b0;
      batteryOvervoltage = 1'b0;
      faultEvents = 8'h00;
      w(4);
      u_host.rd(8'h20, d);
      chk(d, (k == 2) ? 8'h20 : (k == 3) ? 8'h04 : 8'h00);
      w(4);
      chk(outs, 8'hC4);
    end
    @(negedge ref_clk);
    pinVec = 7'h00;
    converterReady = 1'b0;
  endtask : t_good

  task automatic t_faults();
    @(negedge ref_clk);
    faultEvents = 8'h80;
    w(2);
    faultEvents = 8'h00;
    w(4);
    u_host.rd(8'h20, d);
    chk(d, 8'h80);
    u_host.rd(8'h20, d);
    chk(d, 8'h00);
    faultEvents = 8'h10;
    w(4);
    chk({7'h00, converterEnable}, 8'h00);
    faultEvents = 8'h00;
    w(4);
    u_host.rd(8'h20, d);
    chk(d, 8'h10);
    chk({7'h00, converterEnable}, 8'h00);
    u_host.wr(8'h20, 8'h00);
    w(2);
    chk({7'h00, converterEnable}, 8'h01);
    u_host.wr(8'h20, 8'h08);
    u_host.rd(8'h20, d);
    chk(d, 8'h08);
    u_host.wr(8'h20, 8'hEF);
    u_host.wr(8'h21, 8'hFF);
    u_host.rd(8'h20, d);
    chk(d, 8'h08);
    u_host.rd(8'h21, d);
    chk(d, 8'h00);
    u_host.wr(8'h20, 8'h00);
    u_host.rd(8'h22, d);
    chk(d, 8'h00);
  endtask : t_faults

  task automatic t_assist();
    @(negedge ref_clk);
    adapterOkCfg = 1'b1;
    alertCfgLoad = 1'b1;
    @(negedge ref_clk);
    alertCfgLoad = 1'b0;
    u_host.setAssist(1'b1, 1'b1);
    w(5);
    chk(outs, 8'h06);
    u_host.setAssist(1'b1, 1'b0);
    w(4);
    chk(outs, 8'h21);
    u_host.rd(8'h21, d);
    chk(d, 8'h20);
    u_host.setAssist(1'b0, 1'b0);
    w(4);
    chk(outs, 8'h1D);
    u_host.clearExit();
    chk(outs, 8'h05);
    u_host.setAssist(1'b1, 1'b0);
    w(4);
    faultEvents = 8'h02;
    w(4);
    chk(outs, 8'h1D);
    u_host.clearExit();
    w(4);
    chk(outs, 8'h05);
    faultEvents = 8'h00;
    w(4);
    chk(outs, 8'h21);
    u_host.setAssist(1'b1, 1'b1);
    w(4);
    chk(outs, 8'h1D);
    u_host.clearExit();
    u_host.rd(8'h20, d);
    chk(d, 8'h02);
  endtask : t_assist

  // frozen clock enable, a mid-run reset, then an alert source reload
  task automatic t_enable();
    @(negedge ref_clk);
    ce = 1'b0;
    pinVec = 7'h40;
    w(6);
    chk(outs, 8'h05);
    ce = 1'b1;
    w(4);
    chk(outs, 8'h45);
    srst = 1'b1;
    w(3);
    chk(outs, 8'h04);
    srst = 1'b0;
    w(5);
    chk(outs, 8'h44);
    adapterOkCfg = 1'b0;
    systemVoltageCfg = 1'b1;
    alertCfgLoad = 1'b1;
    @(negedge ref_clk);
    alertCfgLoad = 1'b0;
    chk(outs, 8'h45);
    pinVec = 7'h00;
  endtask : t_enable

  initial begin
    fails = 0;
    nTests = 0;
    cycles = 0;
    srst = 1'b1;
    ce = 1'b1;
    pinVec = 7'h00;
    outputVoltageRegulation = 1'b0;
    converterReady = 1'b0;
    thermalShutdown = 1'b0;
    batteryOvervoltage = 1'b0;
    faultEvents = 8'h00;
    alertCfgLoad = 1'b0;
    adapterOkCfg = 1'b0;
    systemVoltageCfg = 1'b0;
    w(16);
    srst = 1'b0;
    w(2);
    t_reset();
    t_status();
    t_good();
    t_faults();
    t_assist();
    t_enable();
    conclude();
  end
endmodule : tb_charger_status_register
